// File: logic/ect_timer_defs.svh
// Offsets, field positions, reset values and timing counts of the 8-bit timer
// Overview of operation
// [R1] Counter clock: CPU/2, /4, /8 or slow
// [R2] Clock select sets repeat period per setting
// [R3] Free-running 8-bit up-counter, two read views
// [R4] Alternate counter read keeps overflow flag
// [R5] Status read then counter read clears overflow
// [R6] Counter register write reloads FCh
// [R7] Reset and reload value is FCh
// [R8] Unbonded capture input reads as one
// [R9] Overflow sets flag, interrupt when enabled
// [R10] Two compare channels, shared interrupt
// [R11] Two capture channels, shared interrupt
// [R12] PWM and one pulse mode bits
// [R13] Control A bit layout
// [R14] Interrupt needs flag and enable
`ifndef ECT_TIMER_DEFS_SVH
`define ECT_TIMER_DEFS_SVH
`define ECT_OFS_CTRL_B   8'h3C
`define ECT_OFS_CTRL_A   8'h3D
`define ECT_OFS_STATUS   8'h3E
`define ECT_OFS_CAP_ONE  8'h3F
`define ECT_OFS_CMP_ONE  8'h40
`define ECT_OFS_CNT      8'h41
`define ECT_OFS_CNT_ALT  8'h42
`define ECT_OFS_CAP_TWO  8'h43
`define ECT_OFS_CMP_TWO  8'h44
`define ECT_OFS_MASK     8'h45
`define ECT_CNT_RELOAD   8'hFC
`define ECT_CNT_TOP      8'hFF
`define ECT_RST_ZERO     8'h00
`define ECT_A_FORCE_TWO  4
`define ECT_A_FORCE_ONE  3
`define ECT_B_ONE_PULSE  5
`define ECT_B_PWM        4
`define ECT_ST_DISABLE   2
`define ECT_SLOW_REPEAT  20480000
`define ECT_CNT_STEPS    256
`endif

// File: logic/ect_pkg.sv
// Types shared by the 8-bit timer
package ect_pkg;
  // Clock select codes
  typedef enum logic [1:0] {
    ECT_DIV2 = 2'b00,
    ECT_DIV4 = 2'b01,
    ECT_DIV8 = 2'b10,
    ECT_SLOW = 2'b11
  } ect_clk_sel_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ect_req_t;
  // Compare waveform pins
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] enable;
  } ect_wave_t;
endpackage

// File: logic/ect_timer.sv
// Eight-bit capture/compare timer with register port and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "ect_timer_defs.svh"
module ect_timer import ect_pkg::*; #(
  parameter int          SLOW_DIV = `ECT_SLOW_REPEAT / `ECT_CNT_STEPS,
  parameter logic [1:0]  BONDED   = 2'b11
) (
  // Clock and reset
  input  wire logic      ref_clk,
  input  wire logic      nrst,
  // Register port
  input  wire ect_req_t  req,
  output logic [7:0]     rdata,
  // Capture pins, asynchronous
  input  wire logic      capture_input_one,
  input  wire logic      capture_input_two,
  // Compare pins
  output ect_wave_t      wave,
  // Interrupt
  output logic           irq
);

  // Refuse divisors the prescaler cannot count
  if (SLOW_DIV < 8 || SLOW_DIV > 131072) begin : g_chk
    $error("SLOW_DIV out of range");
  end

  // Stored registers
  logic [7:0]  ctrl_a_r;     // Interrupt enables, levels, edge one
  logic [7:0]  ctrl_b_r;     // Pin enables, modes, clock select
  logic [7:0]  mask_r;       // Interrupt mask, status layout
  logic [7:0]  cnt_r;        // Free-running counter
  logic [7:0]  cmp_r [2];    // Compare values one and two
  logic [7:0]  cap_r [2];    // Captured values one and two
  logic [4:0]  flags_r;      // cap1, cmp1, ovf, cap2, cmp2
  logic [4:0]  flags_nxt;
  logic [4:0]  seen_r;       // Flags seen by a status read
  logic        dis_r;        // Timer disable
  logic [16:0] pre_r;        // Prescaler count
  logic [1:0]  out_r;        // Compare pin levels
  logic [7:0]  rdata_r;

  // Decoded strobes
  wire logic wr_ctrl_a = req.wr && req.addr == `ECT_OFS_CTRL_A;
  wire logic wr_ctrl_b = req.wr && req.addr == `ECT_OFS_CTRL_B;
  wire logic wr_stat   = req.wr && req.addr == `ECT_OFS_STATUS;
  wire logic wr_mask   = req.wr && req.addr == `ECT_OFS_MASK;
  wire logic wr_cmp1   = req.wr && req.addr == `ECT_OFS_CMP_ONE;
  wire logic wr_cmp2   = req.wr && req.addr == `ECT_OFS_CMP_TWO;
  wire logic wr_cnt    = req.wr && (req.addr == `ECT_OFS_CNT ||
                                    req.addr == `ECT_OFS_CNT_ALT);
  wire logic rd_stat   = req.rd && req.addr == `ECT_OFS_STATUS;
  wire logic rd_cnt    = req.rd && req.addr == `ECT_OFS_CNT;
  wire logic rd_alt    = req.rd && req.addr == `ECT_OFS_CNT_ALT;
  wire logic rd_cap1   = req.rd && req.addr == `ECT_OFS_CAP_ONE;
  wire logic rd_cap2   = req.rd && req.addr == `ECT_OFS_CAP_TWO;
  wire logic acc_cmp1  = (req.rd || req.wr) && req.addr == `ECT_OFS_CMP_ONE;
  wire logic acc_cmp2  = (req.rd || req.wr) && req.addr == `ECT_OFS_CMP_TWO;

  // Control fields
  wire logic         cap_ie    = ctrl_a_r[7];               // [R13]
  wire logic         cmp_ie    = ctrl_a_r[6];
  wire logic         ovf_ie    = ctrl_a_r[5];
  wire logic         lvl_two   = ctrl_a_r[2];
  wire logic [1:0]   cap_edge  = {ctrl_b_r[1], ctrl_a_r[1]};
  wire logic         lvl_one   = ctrl_a_r[0];
  wire logic         pwm_on    = ctrl_b_r[`ECT_B_PWM];       // [R12]
  wire logic         pulse_on  = ctrl_b_r[`ECT_B_ONE_PULSE]; // [R12]
  wire ect_clk_sel_t clk_sel   = ect_clk_sel_t'(ctrl_b_r[3:2]);
  wire logic         force_one = wr_ctrl_a && req.wdata[`ECT_A_FORCE_ONE];
  wire logic         force_two = wr_ctrl_a && req.wdata[`ECT_A_FORCE_TWO];

  // Prescaler limit per clock select
  localparam logic [16:0] SLOW_LIM = 17'(SLOW_DIV - 1);
  wire logic [16:0] pre_lim =
    (clk_sel == ECT_DIV2) ? 17'h00001 :                     // [R1]
    (clk_sel == ECT_DIV4) ? 17'h00003 :
    (clk_sel == ECT_DIV8) ? 17'h00007 : SLOW_LIM;
  wire logic tick = !dis_r && pre_r >= pre_lim;            // [R2]
  wire logic wrap = tick && cnt_r == `ECT_CNT_TOP;

  // Capture edge events
  logic [1:0] cap_ev;
  logic [1:0] pin_raw;
  assign pin_raw = {capture_input_two, capture_input_one};

  // One capture channel per generate pass
  for (genvar i = 0; i < 2; i++) begin : g_cap
    logic s1_r;   // First synchroniser stage
    logic s2_r;   // Second synchroniser stage
    logic s3_r;   // Previous level for edge detection
    // Unbonded pins are seen as a constant one
    wire logic pin = BONDED[i] ? pin_raw[i] : 1'b1;         // [R8]
    // Synchronise and remember
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        s3_r <= 1'b1;
      end else begin
        s1_r <= pin;
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end
    // Edge select: one is rising, zero is falling
    assign cap_ev[i] = cap_edge[i] ? (s2_r && !s3_r)        // [R11]
                                   : (!s2_r && s3_r);
    // Latch counter on the chosen edge
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        cap_r[i] <= `ECT_RST_ZERO;
      end else if (cap_ev[i]) begin
        cap_r[i] <= cnt_r;                                  // [R11]
      end
    end
  end

  // Compare matches on a counter step
  wire logic [1:0] match = {tick && cnt_r == cmp_r[1],
                            tick && cnt_r == cmp_r[0]};     // [R10]
  wire logic restart = pulse_on && cap_ev[0];

  // Prescaler, restarted with the counter
  always_ff @(posedge ref_clk) begin
    if (!nrst || wr_cnt || restart || tick) begin
      pre_r <= 17'h00000;
    end else if (!dis_r) begin
      pre_r <= pre_r + 17'h00001;
    end
  end

  // Free-running up-counter
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_r <= `ECT_CNT_RELOAD;                             // [R7]
    end else if (wr_cnt || restart) begin
      cnt_r <= `ECT_CNT_RELOAD;                             // [R6]
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;                               // [R3]
    end
  end

  // Flag events and clears; a set always wins
  wire logic [4:0] set_v = {cap_ev[0], match[0] && !pwm_on, wrap,
                            cap_ev[1], match[1] && !pwm_on};
  wire logic [4:0] w1c_v = wr_stat ? req.wdata[7:3] : 5'h00;
  wire logic [4:0] rdc_v = seen_r & {rd_cap1, acc_cmp1, rd_cnt,
                                     rd_cap2, acc_cmp2};    // [R5]
  assign flags_nxt = (flags_r & ~(w1c_v | rdc_v)) | set_v;  // [R9]

  // Status flags and the read-sequence memory
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flags_r <= 5'h00;
      seen_r  <= 5'h00;
    end else begin
      flags_r <= flags_nxt;
      seen_r  <= rd_stat ? flags_r : (seen_r & ~rdc_v);
    end
  end

  // Control, mask and disable registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_a_r <= `ECT_RST_ZERO;
      ctrl_b_r <= `ECT_RST_ZERO;
      mask_r   <= `ECT_RST_ZERO;
      dis_r    <= 1'b0;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_r <= req.wdata & 8'hE7;                      // [R13]
      end
      if (wr_ctrl_b) begin
        ctrl_b_r <= req.wdata & 8'hFE;
      end
      if (wr_mask) begin
        mask_r <= req.wdata & 8'hF8;
      end
      if (wr_stat) begin
        dis_r <= req.wdata[`ECT_ST_DISABLE];
      end
    end
  end

  // Compare value registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cmp_r[0] <= `ECT_RST_ZERO;
      cmp_r[1] <= `ECT_RST_ZERO;
    end else begin
      if (wr_cmp1) begin
        cmp_r[0] <= req.wdata;
      end
      if (wr_cmp2) begin
        cmp_r[1] <= req.wdata;
      end
    end
  end

  // Channel one level: force, compare, PWM or one pulse
  // A force takes the level being written in the same cycle, not the
  // stored one, so one write both picks and applies the new level
  wire logic out1_nxt =
    force_one                          ? req.wdata[0] :     // [R13]
    ((pwm_on || pulse_on) && match[0]) ? lvl_one :          // [R12]
    (pwm_on && wrap)                   ? lvl_two :
    restart                            ? lvl_two :
    match[0]                           ? lvl_one : out_r[0]; // [R10]
  // Channel two level: force or compare
  wire logic out2_nxt = force_two ? req.wdata[2] :
                        match[1]  ? lvl_two : out_r[1];

  // Compare pin levels
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      out_r <= 2'b00;
    end else begin
      out_r <= {out2_nxt, out1_nxt};
    end
  end

  // Read data selection
  wire logic [7:0] stat_rd = {flags_r, dis_r, 2'b00};
  wire logic [7:0] rd_mux =
    (req.addr == `ECT_OFS_CTRL_B)  ? ctrl_b_r :
    (req.addr == `ECT_OFS_CTRL_A)  ? ctrl_a_r :
    (req.addr == `ECT_OFS_STATUS)  ? stat_rd :
    (req.addr == `ECT_OFS_CAP_ONE) ? cap_r[0] :
    (req.addr == `ECT_OFS_CMP_ONE) ? cmp_r[0] :
    (req.addr == `ECT_OFS_CNT)     ? cnt_r :                // [R3]
    (req.addr == `ECT_OFS_CNT_ALT) ? cnt_r :                // [R4]
    (req.addr == `ECT_OFS_CAP_TWO) ? cap_r[1] :
    (req.addr == `ECT_OFS_CMP_TWO) ? cmp_r[1] :
    (req.addr == `ECT_OFS_MASK)    ? mask_r : 8'h00;

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (!nrst || !req.rd) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  // Enables per flag, then mask, onto one level output
  wire logic [4:0] en_v = {cap_ie, cmp_ie, ovf_ie, cap_ie, cmp_ie};
  assign irq   = |(flags_r & en_v & mask_r[7:3]);            // [R14]
  assign rdata = rdata_r;
  assign wave.level  = out_r;
  assign wave.enable = {ctrl_b_r[6], ctrl_b_r[7]};

  // Checks on the design's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Status read followed by a counter read
  sequence s_stat_seen;
    rd_stat && flags_r[2];
  endsequence
  sequence s_cnt_read;
    rd_cnt && !wrap;
  endsequence
  // Write-one clear of overflow with no wrap in that cycle
  sequence s_ovf_w1c;
    wr_stat && req.wdata[5] && !wrap;
  endsequence

  a_cnt_reload: assert property ( // [R6]
    wr_cnt |=> cnt_r == 8'hFC)
    else $error("counter not reloaded to FC");

  a_cnt_counts_up: assert property ( // [R3]
    tick && !wr_cnt && !restart |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter did not step up");

  a_ovf_set_wrap: assert property ( // [R9]
    wrap |=> flags_r[2])
    else $error("overflow flag not set on wrap");

  a_alt_keeps_ovf: assert property ( // [R4]
    rd_alt && flags_r[2] |=> flags_r[2])
    else $error("alternate read cleared overflow");

  a_ovf_read_clear: assert property ( // [R5]
    s_stat_seen ##1 s_cnt_read |=> !flags_r[2])
    else $error("overflow flag not cleared by read sequence");

  a_irq_gating: assert property ( // [R14]
    irq |-> |(flags_r & en_v))
    else $error("interrupt without enabled flag");

  a_cap_latch: assert property ( // [R11]
    cap_ev[0] |=> cap_r[0] == $past(cnt_r) && flags_r[4])
    else $error("capture one did not latch counter");

  a_cmp_flag: assert property ( // [R10]
    match[1] && !pwm_on |=> flags_r[0] ##0 wave.level[1] == lvl_two)
    else $error("compare two did not flag");

  a_div2_rate: assert property ( // [R1]
    tick && clk_sel == ECT_DIV2 && !wr_cnt && !restart |=> !tick)
    else $error("divide by two ticked twice in a row");

  a_rdata_cnt: assert property ( // [R3]
    rd_cnt |=> rdata == $past(cnt_r))
    else $error("counter read data wrong");

  // A wrap in the clearing cycle keeps the flag up
  a_ovf_set_wins: assert property ( // [R9]
    wrap && wr_stat |=> flags_r[2])
    else $error("overflow clear beat a wrap");

  // Writing one to the overflow bit clears it
  a_ovf_w1c_clear: assert property ( // [R9]
    s_ovf_w1c |=> !flags_r[2])
    else $error("overflow flag not cleared by write");

  // Enabled and unmasked overflow drives the interrupt
  a_irq_ovf_on: assert property ( // [R14]
    flags_r[2] && ovf_ie && mask_r[5] |-> irq)
    else $error("overflow interrupt missing");

  // No enable bit set means no interrupt
  a_irq_all_off: assert property ( // [R14]
    !cap_ie && !cmp_ie && !ovf_ie |-> !irq)
    else $error("interrupt with all enables off");

  // Channel two capture latches the counter and flags
  a_cap_two_latch: assert property ( // [R11]
    cap_ev[1] |=> cap_r[1] == $past(cnt_r) && flags_r[1])
    else $error("capture two did not latch counter");

  // Channel one compare sets its flag outside PWM
  a_cmp_one_flag: assert property ( // [R10]
    match[0] && !pwm_on |=> flags_r[3])
    else $error("compare one did not flag");

  // A disabled timer holds its count
  a_freeze_holds: assert property ( // [R2]
    dis_r && !wr_cnt && !restart |=> cnt_r == $past(cnt_r))
    else $error("counter moved while disabled");

  // Prescaler never ticks in two cycles in a row
  a_tick_gap: assert property ( // [R1]
    tick |=> !tick)
    else $error("prescaler ticked back to back");

  // Forcing pin one applies the written level
  a_force_one_lvl: assert property ( // [R13]
    force_one |=> wave.level[0] == $past(req.wdata[0]))
    else $error("force one gave wrong level");

  // Forcing pin two applies the written level
  a_force_two_lvl: assert property ( // [R13]
    force_two |=> wave.level[1] == $past(req.wdata[2]))
    else $error("force two gave wrong level");

  // Read data is zero after a cycle without a read
  a_rdata_idle: assert property ( // [R3]
    !req.rd |=> rdata == 8'h00)
    else $error("read data not idle");

  // One pulse restart reloads the counter
  a_pulse_restart: assert property ( // [R12]
    restart |=> cnt_r == 8'hFC)
    else $error("one pulse restart did not reload");

  // Alternate view returns the same count
  a_alt_read_data: assert property ( // [R4]
    rd_alt |=> rdata == $past(cnt_r))
    else $error("alternate counter read data wrong");

endmodule
`default_nettype wire

// File: dv/ect_pin_model.sv
// Far-side model of the capture pins and compare waveform pins
`timescale 1ns/100ps
`default_nettype none
module ect_pin_model import ect_pkg::*; (
  // Clock
  input  wire logic       ref_clk,
  // Pin levels asked for by the bench
  input  wire logic [1:0] set_level,
  // Compare pins from the timer
  input  wire ect_wave_t  wave,
  // Capture pins to the timer
  output logic            capture_input_one,
  output logic            capture_input_two,
  // Level seen on each enabled compare pin, pulled high when not driven
  output logic [1:0]      pin_seen
);
  // Capture pins follow the bench just after a clock edge
  always @(posedge ref_clk) begin
    capture_input_one <= #1 set_level[0];
    capture_input_two <= #1 set_level[1];
  end
  // Undriven pin shows its pull-up level
  assign pin_seen = (wave.level & wave.enable) | ~wave.enable;
endmodule
`default_nettype wire

// File: dv/ect_timer_tb.sv
// Self-checking testbench of the 8-bit capture/compare timer
`timescale 1ns/100ps
`default_nettype none
`include "ect_timer_defs.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("wrong value %s exp %h got %h", nm, ex, got); miscompares++; end end
module ect_timer_tb import ect_pkg::*;;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  ect_req_t   req = '0;
  logic [7:0] rdata;
  logic       cap_one, cap_two;
  ect_wave_t  wave;
  logic       irq;
  logic [1:0] set_level = 2'b11;
  logic [1:0] pin_seen;
  int         miscompares = 0;
  int         check_count = 0;
  logic [7:0] d, e;
  // Clock of 100 MHz
  always #5 ref_clk = ~ref_clk;
  ect_timer #(.SLOW_DIV(8)) ect_timer_i (.ref_clk(ref_clk), .nrst(nrst), .req(req),
    .rdata(rdata), .capture_input_one(cap_one), .capture_input_two(cap_two),
    .wave(wave), .irq(irq));
  ect_pin_model ect_pin_model_i (.ref_clk(ref_clk), .set_level(set_level), .wave(wave),
    .capture_input_one(cap_one), .capture_input_two(cap_two), .pin_seen(pin_seen));
  // Register write, one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) req <= '0;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) req <= '0;
    #1 v = rdata;
  endtask
  task automatic finish_test;
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Poll status until the given bits are all set
  task automatic wait_status(input logic [7:0] m);
    for (int i = 0; i < 700; i++) begin
      rd(`ECT_OFS_STATUS, d);
      if ((d & m) == m) return;
    end
    miscompares++;
    finish_test();
  endtask
  // Reset view of counter, status and an unmapped place
  task automatic t_reset;
    rd(`ECT_OFS_CNT, d);      `CHK("counter", 8'hFC, d)
    // Counter runs at divide by two: one step between the two reads
    rd(`ECT_OFS_CNT_ALT, d);  `CHK("counter alt", 8'hFD, d)
    rd(`ECT_OFS_STATUS, d);   `CHK("status", 8'h00, d)
    rd(8'h50, d);             `CHK("unmapped", 8'h00, d)
  endtask
  // Step count over forty prescaler periods for each clock select
  task automatic t_rate;
    int dv [4] = '{2, 4, 8, 8};
    for (int s = 0; s < 4; s++) begin
      wr(`ECT_OFS_CTRL_B, 8'(s << 2));
      wr(`ECT_OFS_CNT, 8'h00);
      rd(`ECT_OFS_CNT, d);
      repeat (dv[s] * 40 - 2) @(posedge ref_clk);
      rd(`ECT_OFS_CNT_ALT, e);
      `CHK("steps", 8'h28, 8'(e - d))
    end
    wr(`ECT_OFS_CTRL_B, 8'h00);
  endtask
  // Write to either counter view reloads FC whatever the data
  task automatic t_reload;
    wr(`ECT_OFS_STATUS, 8'h04);
    wr(`ECT_OFS_CNT_ALT, 8'h37);
    rd(`ECT_OFS_CNT, d);      `CHK("reload", 8'hFC, d)
    wr(`ECT_OFS_STATUS, 8'h00);
    repeat (20) @(posedge ref_clk);
    wr(`ECT_OFS_STATUS, 8'h04);
    wr(`ECT_OFS_CNT, 8'h00);
    rd(`ECT_OFS_CNT_ALT, d);  `CHK("reload two", 8'hFC, d)
    wr(`ECT_OFS_STATUS, 8'h00);
  endtask
  // Overflow flag, interrupt gating and the two clear paths
  task automatic t_ovf;
    wr(`ECT_OFS_STATUS, 8'hF8);
    wr(`ECT_OFS_MASK, 8'h20);
    wr(`ECT_OFS_CTRL_A, 8'h00);
    wr(`ECT_OFS_CNT, 8'h00);
    wait_status(8'h20);
    `CHK("irq off", 1'b0, irq)
    wr(`ECT_OFS_CTRL_A, 8'h20);
    #1 `CHK("irq on", 1'b1, irq)
    rd(`ECT_OFS_CNT_ALT, d);
    rd(`ECT_OFS_STATUS, d);   `CHK("ovf kept", 1'b1, d[5])
    rd(`ECT_OFS_CNT, d);
    rd(`ECT_OFS_STATUS, d);   `CHK("ovf cleared", 1'b0, d[5])
    `CHK("irq low", 1'b0, irq)
    wait_status(8'h20);
    wr(`ECT_OFS_STATUS, 8'h20);
    #1 `CHK("irq w1c", 1'b0, irq)
  endtask
  // Both compare channels, pins, flags, shared interrupt and forcing
  task automatic t_cmp;
    wr(`ECT_OFS_CTRL_A, 8'h00);
    wr(`ECT_OFS_STATUS, 8'hF8);
    wr(`ECT_OFS_MASK, 8'h48);
    wr(`ECT_OFS_CMP_ONE, 8'h10);
    wr(`ECT_OFS_CMP_TWO, 8'h20);
    wr(`ECT_OFS_CTRL_B, 8'hC0);
    wr(`ECT_OFS_CTRL_A, 8'h45);
    wait_status(8'h48);
    `CHK("pins", 2'b11, pin_seen)
    `CHK("enables", 2'b11, wave.enable)
    `CHK("cmp irq", 1'b1, irq)
    wr(`ECT_OFS_STATUS, 8'h48);
    #1 `CHK("cmp irq clr", 1'b0, irq)
    wr(`ECT_OFS_CTRL_A, 8'h18);
    repeat (2) @(posedge ref_clk);
    `CHK("forced", 2'b00, wave.level)
    rd(`ECT_OFS_STATUS, d);   `CHK("no flag", 2'b00, {d[6], d[3]})
    wr(`ECT_OFS_CTRL_A, 8'h1D);
    repeat (2) @(posedge ref_clk);
    `CHK("forced one", 2'b11, wave.level)
    wr(`ECT_OFS_CTRL_B, 8'h00);
  endtask
  // Capture on both channels with a frozen counter
  task automatic t_cap;
    wr(`ECT_OFS_STATUS, 8'hFC);
    wr(`ECT_OFS_CNT, 8'h00);
    wr(`ECT_OFS_MASK, 8'h90);
    wr(`ECT_OFS_CTRL_A, 8'h82);
    @(posedge ref_clk) set_level <= 2'b00;
    repeat (8) @(posedge ref_clk);
    rd(`ECT_OFS_STATUS, d);   `CHK("cap two only", 8'h14, d)
    @(posedge ref_clk) set_level <= 2'b01;
    repeat (8) @(posedge ref_clk);
    `CHK("cap irq", 1'b1, irq)
    rd(`ECT_OFS_STATUS, d);   `CHK("cap both", 8'h94, d)
    rd(`ECT_OFS_CAP_ONE, d);  `CHK("cap one", 8'hFC, d)
    rd(`ECT_OFS_CAP_TWO, d);  `CHK("cap two", 8'hFC, d)
    rd(`ECT_OFS_STATUS, d);   `CHK("cap clr", 8'h04, d)
    `CHK("cap irq clr", 1'b0, irq)
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_rate();
    t_reload();
    t_ovf();
    t_cmp();
    t_cap();
    finish_test();
  end
endmodule
`default_nettype wire
